// ---- rtl/mpea_pkg.sv ----
// Shared constants for the memory port check-code datapath
package mpea_pkg;

   // ************************************************************
   // Bus widths and response codes
   // ************************************************************
   localparam int AXI_ADDR_W = 32;
   localparam int AXI_DATA_W = 32;
   localparam int AXI_STRB_W = 4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ************************************************************
   // Register window
   // ************************************************************
   localparam int REG_SEL_BIT = 17;
   localparam int REG_OFS_W = 8;
   localparam logic [7:0] REG_STATUS_OFS = 8'h00;
   localparam logic [7:0] REG_MASK_OFS = 8'h04;
   localparam logic [7:0] REG_CTRL_OFS = 8'h08;
   localparam logic [7:0] REG_CECNT_OFS = 8'h0C;
   localparam logic [7:0] REG_ERRADDR_OFS = 8'h10;
   localparam int FLAG_W = 2;
   localparam int STAT_CE = 0;
   localparam int STAT_UE = 1;
   localparam int CTRL_CHECK_EN = 0;
   localparam int CTRL_SLVERR_EN = 1;
   localparam logic [1:0] CTRL_SLVERR_RST = 2'h2;
   localparam int CE_CNT_W = 8;

   // ************************************************************
   // Memory geometry
   // ************************************************************
   localparam int MIN_ADDR_W = 10;
   localparam int MAX_ADDR_BIT = 16;
   localparam int MAX_MEM_W = 128;
   localparam int MAX_CHK_W = 9;
   localparam int HOST_W_NO_CHECK = 256;
   localparam int WORD_LSB = 2;
   localparam int BYTE_SHIFT = 3;

   function automatic int mpeaAddrLsb(input int memW);
      return (memW == 128) ? 4 : (memW == 64) ? 3 : 2;
   endfunction

   function automatic int mpeaChkWidth(input int memW);
      return (memW == 128) ? 9 : (memW == 64) ? 8 : 7;
   endfunction

   function automatic int mpeaChkWeCount(input int memW);
      return (memW == 128) ? 2 : 1;
   endfunction

   // Data columns: weight-3 codes ascending, then weight-5
   function automatic logic [MAX_MEM_W*MAX_CHK_W-1:0] mpeaHMatrix(input int chkW);
      logic [MAX_MEM_W*MAX_CHK_W-1:0] m;
      int n;
      m = '0;
      n = 0;
      for (int wt = 3; wt <= 5; wt += 2) begin
         for (int v = 1; v < (1 << chkW); v++) begin
            if ($countones(v) == wt && n < MAX_MEM_W) begin
               m[n*MAX_CHK_W +: MAX_CHK_W] = v[MAX_CHK_W-1:0];
               n++;
            end
         end
      end
      return m;
   endfunction

endpackage

// ---- rtl/mpea_memory_port_ecc.sv ----
// AXI4-Lite fronted memory port with address mapping and SEC-DED check codes
`timescale 1ns/1ns

module mpea_memory_port_ecc
   import mpea_pkg::*;
#(
   parameter int MEM_W = 32,
   parameter int MEM_ADDR_W = 10,
   parameter int ECC_OPTION = 1,
   parameter int SINGLE_PORT_OPTION = 0,
   parameter bit CHECK_ENABLE_RESET_VALUE = 1'b1,
   parameter int HOST_DATA_W = 32,
   localparam int ADDR_LSB = mpeaAddrLsb(MEM_W),
   localparam int ADDR_MAX_W = MAX_ADDR_BIT + 1 - ADDR_LSB,
   localparam int ADDR_W = (MEM_ADDR_W < MIN_ADDR_W) ? MIN_ADDR_W :
                           (MEM_ADDR_W > ADDR_MAX_W) ? ADDR_MAX_W : MEM_ADDR_W,
   localparam int CHK_W = mpeaChkWidth(MEM_W),
   localparam int CHK_WE_W = mpeaChkWeCount(MEM_W),
   localparam int BYTES = MEM_W / 8
)(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [ADDR_W-1:0] memoryWordAddressA,
   output logic memEnA,
   output logic [BYTES-1:0] memWeA,
   output logic [MEM_W-1:0] memWrDataA,
   output logic [CHK_W-1:0] memChkWrA,
   output logic [CHK_WE_W-1:0] memChkWeA,
   input wire logic [MEM_W-1:0] memRdDataA,
   input wire logic [CHK_W-1:0] memRdChkA,
   output logic [ADDR_W-1:0] memoryWordAddressB,
   output logic memEnB,
   input wire logic [MEM_W-1:0] memRdDataB,
   input wire logic [CHK_W-1:0] memRdChkB,
   output logic irq
);

   // ************************************************************
   // Configuration
   // ************************************************************
   // supported widths only
   localparam bit ECC_ACTIVE = (ECC_OPTION == 1) && (MEM_W == 32 || MEM_W == 64 || MEM_W == 128) &&
                               (HOST_DATA_W < HOST_W_NO_CHECK);
   localparam bit SINGLE_PORT = (SINGLE_PORT_OPTION == 1);
   localparam int LANES = MEM_W / AXI_DATA_W;
   localparam logic [MAX_MEM_W*MAX_CHK_W-1:0] H_ALL = mpeaHMatrix(CHK_W);
   localparam logic [FLAG_W-1:0] CTRL_RST = CTRL_SLVERR_RST | FLAG_W'(CHECK_ENABLE_RESET_VALUE);

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_MEMRD = 4'h2,
      ST_CAPT = 4'h4,
      ST_MEMWR = 4'h8
   } mpea_state_t;

   typedef struct packed {
      mpea_state_t st;
      logic awHeld;
      logic [AXI_ADDR_W-1:0] awAddr;
      logic wHeld;
      logic [AXI_DATA_W-1:0] wData;
      logic [AXI_STRB_W-1:0] wStrb;
      logic arHeld;
      logic [AXI_ADDR_W-1:0] arAddr;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [1:0] rResp;
      logic [AXI_DATA_W-1:0] rData;
      logic lastWasRead;
      logic opRead;
      logic [AXI_ADDR_W-1:0] opAddr;
      logic [ADDR_W-1:0] addrA;
      logic enA;
      logic [BYTES-1:0] weA;
      logic [MEM_W-1:0] wrDataA;
      logic [CHK_W-1:0] chkWrA;
      logic [CHK_WE_W-1:0] chkWeA;
      logic [ADDR_W-1:0] addrB;
      logic enB;
      logic [FLAG_W-1:0] status;
      logic [FLAG_W-1:0] mask;
      logic [FLAG_W-1:0] ctrl;
      logic [CE_CNT_W-1:0] ceCount;
      logic [ADDR_W-1:0] errAddr;
   } mpea_regs_t;

   mpea_regs_t state_reg;
   mpea_regs_t state_next;

   // ************************************************************
   // Helpers
   // ************************************************************
   // drop byte offset bits
   function automatic logic [ADDR_W-1:0] wordAddr(input logic [AXI_ADDR_W-1:0] a);
      return a[ADDR_LSB +: ADDR_W];
   endfunction

   function automatic logic [BYTES-1:0] laneStrb(input logic [AXI_ADDR_W-1:0] a, input logic [AXI_STRB_W-1:0] s);
      logic [BYTES-1:0] wide;
      wide = BYTES'(s);
      return wide << (a[ADDR_LSB-1:0] >> WORD_LSB << WORD_LSB);
   endfunction

   function automatic logic [CHK_W-1:0] encodeChk(input logic [MEM_W-1:0] d);
      logic [CHK_W-1:0] c;
      c = '0;
      for (int i = 0; i < MEM_W; i++) begin
         if (d[i]) begin
            c = c ^ H_ALL[i*MAX_CHK_W +: CHK_W];
         end
      end
      return c;
   endfunction

   // ************************************************************
   // Decode of the word returned by memory
   // ************************************************************
   logic [MEM_W-1:0] rawWord;
   logic [CHK_W-1:0] rawChk;
   logic [CHK_W-1:0] syndrome;
   logic [MEM_W-1:0] flipBits;
   logic [MEM_W-1:0] fixedWord;
   logic [MEM_W-1:0] mergedWord;
   logic [MEM_W-1:0] wideData;
   logic [BYTES-1:0] opStrb;
   logic [MEM_W-1:0] shiftedWord;
   logic checkOn;
   logic singleErr;
   logic multiErr;

   assign rawWord = (state_reg.opRead && !SINGLE_PORT) ? memRdDataB : memRdDataA;
   assign rawChk = (state_reg.opRead && !SINGLE_PORT) ? memRdChkB : memRdChkA;
   assign checkOn = ECC_ACTIVE && state_reg.ctrl[CTRL_CHECK_EN];
   assign syndrome = encodeChk(rawWord) ^ rawChk;

   // locate the failing bit by matching a column
   genvar gi;
   generate
      for (gi = 0; gi < MEM_W; gi++) begin : g_flip
         assign flipBits[gi] = (syndrome == H_ALL[gi*MAX_CHK_W +: CHK_W]);
      end
   endgenerate

   // odd weight is single; unmatched is uncorrectable
   assign singleErr = checkOn && (|syndrome) && (^syndrome) && ((|flipBits) || $onehot(syndrome));
   assign multiErr = checkOn && (|syndrome) && !singleErr;
   // correct single bit errors before use
   assign fixedWord = singleErr ? (rawWord ^ flipBits) : rawWord;

   assign wideData = {LANES{state_reg.wData}};
   assign opStrb = laneStrb(state_reg.opAddr, state_reg.wStrb);
   assign shiftedWord = fixedWord >> (int'(state_reg.opAddr[ADDR_LSB-1:0] >> WORD_LSB) * AXI_DATA_W);

   // strobe bit k picks byte k
   generate
      for (gi = 0; gi < BYTES; gi++) begin : g_merge
         assign mergedWord[gi*8 +: 8] = opStrb[gi] ? wideData[gi*8 +: 8] : fixedWord[gi*8 +: 8];
      end
   endgenerate

   // ************************************************************
   // Register read data
   // ************************************************************
   logic [AXI_DATA_W-1:0] regRdData;
   logic regRdHit;

   always_comb begin
      regRdData = '0;
      regRdHit = 1'b1;
      unique case (state_reg.arAddr[REG_OFS_W-1:0])
         REG_STATUS_OFS: regRdData = AXI_DATA_W'(state_reg.status);
         REG_MASK_OFS: regRdData = AXI_DATA_W'(state_reg.mask);
         REG_CTRL_OFS: regRdData = AXI_DATA_W'(state_reg.ctrl);
         REG_CECNT_OFS: regRdData = AXI_DATA_W'(state_reg.ceCount);
         REG_ERRADDR_OFS: regRdData = AXI_DATA_W'(state_reg.errAddr);
         default: regRdHit = 1'b0;
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic startW;
      logic startR;
      logic [FLAG_W-1:0] statusSet;
      logic [FLAG_W-1:0] statusClr;
      state_next = state_reg;
      statusSet = '0;
      statusClr = '0;
      startW = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
      startR = state_reg.arHeld && !state_reg.rValid;
      state_next.enA = 1'b0;
      state_next.weA = '0;
      state_next.chkWeA = '0;
      state_next.enB = 1'b0;
      if (!state_reg.awHeld && s_axi_awvalid) begin
         state_next.awHeld = 1'b1;
         state_next.awAddr = s_axi_awaddr;
      end
      if (!state_reg.wHeld && s_axi_wvalid) begin
         state_next.wHeld = 1'b1;
         state_next.wData = s_axi_wdata;
         state_next.wStrb = s_axi_wstrb;
      end
      if (!state_reg.arHeld && s_axi_arvalid) begin
         state_next.arHeld = 1'b1;
         state_next.arAddr = s_axi_araddr;
      end
      if (state_reg.bValid && s_axi_bready) begin
         state_next.bValid = 1'b0;
      end
      if (state_reg.rValid && s_axi_rready) begin
         state_next.rValid = 1'b0;
      end
      unique case (state_reg.st)
         ST_IDLE: begin
            // Alternate on ties so neither direction starves
            if (startW && (!startR || state_reg.lastWasRead)) begin
               state_next.awHeld = 1'b0;
               state_next.lastWasRead = 1'b0;
               state_next.opRead = 1'b0;
               state_next.opAddr = state_reg.awAddr;
               state_next.bResp = RESP_OKAY;
               state_next.addrA = wordAddr(state_reg.awAddr);
               if (state_reg.awAddr[REG_SEL_BIT]) begin
                  state_next.wHeld = 1'b0;
                  state_next.bValid = 1'b1;
                  if (!ECC_ACTIVE) begin
                     state_next.bResp = RESP_DECERR;
                  end else if (state_reg.awAddr[REG_OFS_W-1:0] == REG_STATUS_OFS) begin
                     statusClr = state_reg.wStrb[0] ? state_reg.wData[FLAG_W-1:0] : '0;
                  end else if (state_reg.awAddr[REG_OFS_W-1:0] == REG_MASK_OFS) begin
                     state_next.mask = state_reg.wStrb[0] ? state_reg.wData[FLAG_W-1:0] : state_reg.mask;
                  end else if (state_reg.awAddr[REG_OFS_W-1:0] == REG_CTRL_OFS) begin
                     state_next.ctrl = state_reg.wStrb[0] ? state_reg.wData[FLAG_W-1:0] : state_reg.ctrl;
                  end else if (state_reg.awAddr[REG_OFS_W-1:0] != REG_CECNT_OFS &&
                               state_reg.awAddr[REG_OFS_W-1:0] != REG_ERRADDR_OFS) begin
                     state_next.bResp = RESP_SLVERR;
                  end
               end else if (ECC_ACTIVE) begin
                  state_next.enA = 1'b1;
                  state_next.st = ST_MEMRD;
               end else begin
                  state_next.wHeld = 1'b0;
                  state_next.enA = 1'b1;
                  state_next.weA = laneStrb(state_reg.awAddr, state_reg.wStrb);
                  state_next.wrDataA = {LANES{state_reg.wData}};
                  state_next.st = ST_MEMWR;
               end
            end else if (startR) begin
               state_next.arHeld = 1'b0;
               state_next.lastWasRead = 1'b1;
               state_next.opRead = 1'b1;
               state_next.opAddr = state_reg.arAddr;
               if (state_reg.arAddr[REG_SEL_BIT]) begin
                  state_next.rValid = 1'b1;
                  state_next.rData = regRdData;
                  state_next.rResp = !ECC_ACTIVE ? RESP_DECERR : regRdHit ? RESP_OKAY : RESP_SLVERR;
               end else begin
                  // reads use port B unless wired single port
                  if (SINGLE_PORT) begin
                     state_next.addrA = wordAddr(state_reg.arAddr);
                     state_next.enA = 1'b1;
                  end else begin
                     state_next.addrB = wordAddr(state_reg.arAddr);
                     state_next.enB = 1'b1;
                  end
                  state_next.st = ST_MEMRD;
               end
            end
         end
         ST_MEMRD: begin
            state_next.st = ST_CAPT;
         end
         ST_CAPT: begin
            if (singleErr) begin
               statusSet[STAT_CE] = 1'b1;
               state_next.errAddr = wordAddr(state_reg.opAddr);
               if (state_reg.ceCount != '1) begin
                  state_next.ceCount = state_reg.ceCount + CE_CNT_W'(1);
               end
            end
            if (multiErr) begin
               statusSet[STAT_UE] = 1'b1;
               state_next.errAddr = wordAddr(state_reg.opAddr);
            end
            if (state_reg.opRead) begin
               state_next.rValid = 1'b1;
               state_next.rData = shiftedWord[AXI_DATA_W-1:0];
               state_next.rResp = (multiErr && state_reg.ctrl[CTRL_SLVERR_EN]) ? RESP_SLVERR : RESP_OKAY;
               state_next.st = ST_IDLE;
            end else begin
               state_next.wHeld = 1'b0;
               state_next.enA = 1'b1;
               state_next.weA = '1;
               state_next.wrDataA = mergedWord;
               // fresh check bits stored with the data
               state_next.chkWrA = encodeChk(mergedWord);
               state_next.chkWeA = '1;
               state_next.bResp = (multiErr && state_reg.ctrl[CTRL_SLVERR_EN]) ? RESP_SLVERR : RESP_OKAY;
               state_next.st = ST_MEMWR;
            end
         end
         ST_MEMWR: begin
            state_next.bValid = 1'b1;
            state_next.st = ST_IDLE;
         end
      endcase
      // A new event beats a simultaneous clear
      state_next.status = (state_reg.status & ~statusClr) | statusSet;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0;
         state_reg.st <= ST_IDLE;
         state_reg.ctrl <= CTRL_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign s_axi_awready = !state_reg.awHeld;
   assign s_axi_wready = !state_reg.wHeld;
   assign s_axi_arready = !state_reg.arHeld;
   assign s_axi_bvalid = state_reg.bValid;
   assign s_axi_bresp = state_reg.bResp;
   assign s_axi_rvalid = state_reg.rValid;
   assign s_axi_rresp = state_reg.rResp;
   assign s_axi_rdata = state_reg.rData;
   assign memoryWordAddressA = state_reg.addrA;
   assign memEnA = state_reg.enA;
   assign memWeA = state_reg.weA;
   assign memWrDataA = state_reg.wrDataA;
   assign memChkWrA = state_reg.chkWrA;
   assign memChkWeA = state_reg.chkWeA;
   assign memoryWordAddressB = state_reg.addrB;
   assign memEnB = state_reg.enB;
   // level interrupt from unmasked sticky flags
   assign irq = |(state_reg.status & state_reg.mask);

endmodule

// ---- tb/mpea_tb_pkg.sv ----
// Bench-side reference encoder for the 32-bit check code
package mpea_tb_pkg;

   // Data bit i takes the i-th odd code, weight 3 before weight 5
   function automatic logic [6:0] mpeaCheckBits(input logic [31:0] d);
      logic [6:0] c;
      int n;
      c = '0;
      n = 0;
      for (int wt = 3; wt <= 5; wt += 2) begin
         for (int v = 1; v < 128; v++) begin
            if ($countones(v) == wt) begin
               if (n < 32 && d[n]) begin
                  c ^= v[6:0];
               end
               n++;
            end
         end
      end
      return c;
   endfunction

endpackage

// ---- tb/mpea_mem_model.sv ----
// Behavioural block memory with stored check bits and read-side bit flips
`timescale 1ns/1ns
module mpea_mem_model (
   input wire logic core_clk,
   input wire logic memEnA,
   input wire logic [9:0] memoryWordAddressA,
   input wire logic [3:0] memWeA,
   input wire logic [31:0] memWrDataA,
   input wire logic [6:0] memChkWrA,
   input wire logic memChkWeA,
   input wire logic memEnB,
   input wire logic [9:0] memoryWordAddressB,
   input wire logic [38:0] flipMask,
   output logic [31:0] memRdDataA,
   output logic [6:0] memRdChkA,
   output logic [31:0] memRdDataB,
   output logic [6:0] memRdChkB
);
   logic [31:0] mem [1024];
   logic [6:0] chk [1024];

   // Zero words carry a valid all-zero code, so partial writes never merge unknowns
   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = '0;
         chk[i] = '0;
      end
      memRdDataA = '0;
      memRdChkA = '0;
      memRdDataB = '0;
      memRdChkB = '0;
   end

   always @(posedge core_clk) begin
      for (int k = 0; k < 4; k++) begin
         if (memEnA && memWeA[k]) begin
            mem[memoryWordAddressA][k*8 +: 8] <= memWrDataA[k*8 +: 8];
         end
      end
      if (memEnA && memChkWeA) begin
         chk[memoryWordAddressA] <= memChkWrA;
      end
      // Idle read lines toggle so stale data never looks like an answer
      {memRdChkA, memRdDataA} <= memEnA ? {chk[memoryWordAddressA], mem[memoryWordAddressA]} ^ flipMask
                                        : ~{memRdChkA, memRdDataA};
      {memRdChkB, memRdDataB} <= memEnB ? {chk[memoryWordAddressB], mem[memoryWordAddressB]} ^ flipMask
                                        : ~{memRdChkB, memRdDataB};
   end
endmodule

// ---- tb/mpea_memory_port_ecc_asserts.sv ----
// Port-level checker for the memory port check-code datapath
`timescale 1ns/1ns
module mpea_memory_port_ecc_asserts
   import mpea_tb_pkg::*;
#(
   parameter int ADDR_W = 10,
   parameter int MEM_W = 32,
   parameter int CHK_W = 7,
   parameter int CHK_WE_W = 1
)(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] memoryWordAddressA,
   input wire logic memEnA,
   input wire logic [MEM_W/8-1:0] memWeA,
   input wire logic [MEM_W-1:0] memWrDataA,
   input wire logic [CHK_W-1:0] memChkWrA,
   input wire logic [CHK_WE_W-1:0] memChkWeA,
   input wire logic [ADDR_W-1:0] memoryWordAddressB,
   input wire logic memEnB,
   input wire logic irq
);
   logic [31:0] lastArReg;
   logic memWrite;

   assign memWrite = memEnA && (|memWeA);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lastArReg <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         lastArReg <= s_axi_araddr;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_we_a: assert property (memWrite |-> memChkWeA == '1)
      else $error("no check enable");
   rmw_read_a: assert property (memWrite |-> $past(memEnA, 2) && $past(memWeA, 2) == '0
      && $past(memoryWordAddressA, 2) == memoryWordAddressA) else $error("no read before write");
   full_word_a: assert property (memWrite |-> memWeA == '1)
      else $error("partial word write");
   chk_bits_a: assert property (memWrite |-> memChkWrA == mpeaCheckBits(memWrDataA[31:0]))
      else $error("wrong check bits");
   word_addr_a: assert property (memEnB |-> memoryWordAddressB == lastArReg[2 +: ADDR_W])
      else $error("wrong word address");
   read_lat_a: assert property (memEnB |-> ##2 s_axi_rvalid)
      else $error("late read answer");
   write_resp_a: assert property (memWrite |=> s_axi_bvalid)
      else $error("late write answer");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read answer moved");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer moved");

   rmw_seen_c: cover property (memWrite);
   slverr_seen_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   irq_seen_c: cover property ($rose(irq));
endmodule

bind mpea_memory_port_ecc mpea_memory_port_ecc_asserts #(.ADDR_W(ADDR_W), .MEM_W(MEM_W), .CHK_W(CHK_W),
   .CHK_WE_W(CHK_WE_W)) i_mpea_memory_port_ecc_asserts (.core_clk, .rstn, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .memoryWordAddressA, .memEnA, .memWeA, .memWrDataA, .memChkWrA, .memChkWeA,
   .memoryWordAddressB, .memEnB, .irq);

// ---- tb/tb.sv ----
// Self-checking bench for the memory port check-code datapath
`timescale 1ns/1ns
module tb;
   import mpea_pkg::*;
   import mpea_tb_pkg::*;
   logic core_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, memEnA, memEnB, irq, memChkWeA;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, memWrDataA, memRdDataA, memRdDataB;
   logic [3:0] s_axi_wstrb, memWeA;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [9:0] memoryWordAddressA, memoryWordAddressB;
   logic [6:0] memChkWrA, memRdChkA, memRdChkB;
   logic [38:0] flipMask;
   int failures, samples_checked;

   mpea_memory_port_ecc i_mpea_memory_port_ecc (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .memoryWordAddressA, .memEnA, .memWeA, .memWrDataA, .memChkWrA, .memChkWeA, .memRdDataA, .memRdChkA,
      .memoryWordAddressB, .memEnB, .memRdDataB, .memRdChkB, .irq);
   mpea_mem_model i_mpea_mem_model (.core_clk, .memEnA, .memoryWordAddressA, .memWeA, .memWrDataA, .memChkWrA,
      .memChkWeA, .memEnB, .memoryWordAddressB, .flipMask, .memRdDataA, .memRdChkA, .memRdDataB, .memRdChkB);

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [38:0] seen, input logic [38:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ************************************************************
   // Bus master
   // ************************************************************
   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      bit b = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      for (int n = 0; n < 200 && !b; n++) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         b = s_axi_bvalid && s_axi_bready;
         r = s_axi_bresp;
         s_axi_bready <= s_axi_bvalid && !s_axi_bready;
      end
      if (!b) begin
         failures++;
         stop_test();
      end
   endtask

   task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      bit b = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (int n = 0; n < 200 && !b; n++) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         b = s_axi_rvalid && s_axi_rready;
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= s_axi_rvalid && !s_axi_rready;
      end
      if (!b) begin
         failures++;
         stop_test();
      end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic testMemRw();
      logic [31:0] addrs [2] = '{32'h0000_0010, 32'h0000_0FFC};
      logic [31:0] pats [2] = '{32'h1234_5678, 32'hCAFE_0F0F};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 2; i++) begin
         axiWrite(addrs[i], pats[i], 4'hF, r);
         check("bresp", r, RESP_OKAY);
         check("stored word", i_mpea_mem_model.mem[addrs[i][11:2]], pats[i]);
         check("stored code", i_mpea_mem_model.chk[addrs[i][11:2]], mpeaCheckBits(pats[i]));
         axiRead(addrs[i] + 32'(i), d, r);
         check("rdata", d, pats[i]);
      end
      axiRead(32'h0002_0008, d, r);
      check("ctrl reset", d, 32'h0000_0003);
      $display("done memory access");
   endtask

   task automatic testMerge();
      logic [1:0] r;
      axiWrite(32'h0000_0020, 32'h0000_0000, 4'hF, r);
      for (int k = 0; k < 4; k++) begin
         axiWrite(32'h0000_0020 + 32'(k), {4{8'hA0 + 8'(k)}}, 4'(1 << k), r);
      end
      check("merged word", i_mpea_mem_model.mem[8], 32'hA3A2_A1A0);
      check("merged code", i_mpea_mem_model.chk[8], mpeaCheckBits(32'hA3A2_A1A0));
      $display("done strobe merge");
   endtask

   task automatic testErrors();
      int pos [4] = '{0, 17, 31, 35};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 4; i++) begin
         flipMask <= 39'h1 << pos[i];
         axiRead(32'h0000_0010, d, r);
         check("corrected", d, 32'h1234_5678);
         check("single resp", r, RESP_OKAY);
      end
      flipMask <= 39'h3;
      axiRead(32'h0000_0010, d, r);
      check("double resp", r, RESP_SLVERR);
      flipMask <= '0;
      axiRead(32'h0002_0000, d, r);
      check("status", d, 32'h0000_0003);
      axiWrite(32'h0002_0004, 32'h0000_0003, 4'hF, r);
      @(negedge core_clk);
      check("irq set", irq, 1'b1);
      axiWrite(32'h0002_0000, 32'h0000_0003, 4'hF, r);
      @(negedge core_clk);
      check("irq clear", irq, 1'b0);
      axiRead(32'h0002_0020, d, r);
      check("unmapped", r, RESP_SLVERR);
      axiWrite(32'h0002_0008, 32'h0000_0002, 4'hF, r);
      flipMask <= 39'h3;
      axiRead(32'h0000_0010, d, r);
      flipMask <= '0;
      check("raw data", d, 32'h1234_567B);
      check("raw resp", r, RESP_OKAY);
      $display("done errors");
   endtask

   initial begin
      rstn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = '0;
      flipMask = '0;
      failures = 0;
      samples_checked = 0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      testMemRw();
      testMerge();
      testErrors();
      stop_test();
   end
endmodule
